// file: rtl/spm_pkg.sv
package spm_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int NARROW_W = 64; // Narrow vector width
	localparam int WIDE_W = 128; // Wide vector width
	localparam int SCALAR_W = 32; // Scalar destination width
	localparam int SEL_W = 8; // Shuffle selector byte width

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [127:0] RESULT_RST = 128'h0; // Result register reset
	localparam logic [31:0] SCALAR_RST = 32'h0; // Scalar result reset

	// ----------------------------------------------------------------
	// Operation codes
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		SPM_OP_NOP,
		SPM_OP_MASK_NARROW,
		SPM_OP_MASK_WIDE,
		SPM_OP_WORD_SHUF_64,
		SPM_OP_LOW_HALF_SHUF,
		SPM_OP_HIGH_HALF_SHUF,
		SPM_OP_DWORD_SHUF,
		SPM_OP_BYTE_PERMUTE,
		SPM_OP_QUAD_LOW,
		SPM_OP_QUAD_HIGH,
		SPM_OP_NARROW_TO_WIDE,
		SPM_OP_WIDE_TO_NARROW,
		SPM_OP_CVT_SP_TO_INT,
		SPM_OP_CVT_INT_TO_SP,
		SPM_OP_CVT_DP_TO_INT,
		SPM_OP_CVT_INT_TO_DP,
		SPM_OP_XOR,
		SPM_OP_CMPEQ,
		SPM_OP_SUB,
		SPM_OP_SHR,
		SPM_OP_SHL
	} spm_op_type;

	// Packed-field granularity
	typedef enum logic [1:0] {
		SPM_G_BYTE,
		SPM_G_WORD,
		SPM_G_DWORD
	} spm_gran_type;

	// Request from the decoder
	typedef struct packed {
		logic valid;
		spm_op_type op;
		spm_gran_type gran;
		logic [7:0] sel;
		logic [5:0] shamt;
		logic [127:0] dst;
		logic [127:0] src;
	} spm_req_type;

	// Registered result
	typedef struct packed {
		logic vec_we;
		logic scalar_we;
		logic [127:0] vec;
		logic [31:0] scalar;
	} spm_res_type;

endpackage : spm_pkg

// file: rtl/spm_unit.sv
// Contract
// - Mask bit i is MSB of byte i
// - Narrow mask: 8 bits, upper 24 cleared
// - Wide mask: 16 bits, upper 16 cleared
// - Selector byte picks any word per destination
// - Selector pairs map to words 0..3
// - Each pair is binary source word index
// - Half shuffles permute half, pass other
// - Dword shuffle routes any dword anywhere
// - Byte permute within 16 bytes
// - Quad interleave low or high halves
// - Unused halves do not affect result
// - Narrow to wide clears high half
// - Wide to narrow takes low half
// - Float/int conversions, four-wide single and two-wide double
// - No immediate constant load operation
// - Self XOR zero, self compare all ones
// - Zero minus ones gives one per field
// - Logical right shift of ones gives 2^n-1
// - Left shift of ones gives -2^n
// - Shifts only word and dword granularity
`timescale 1ns/1ps
module spm_unit #(
	parameter int NUM_BYTES = 16 // Bytes in the wide vector
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire spm_pkg::spm_req_type req_i,
	output spm_pkg::spm_res_type res_o
);
	import spm_pkg::*;

	// ----------------------------------------------------------------
	// Local declarations
	// ----------------------------------------------------------------
	spm_res_type res_ff; // Result register
	spm_res_type nxt_res; // Next result
	logic [15:0] sign_mask; // Byte sign bits
	logic [63:0] shuf_lo; // Low half shuffled
	logic [63:0] shuf_hi; // High half shuffled
	logic [127:0] dshuf; // Dword shuffle
	logic [127:0] bperm; // Byte permute
	logic [127:0] cvt_s2i; // Single to int
	logic [127:0] cvt_i2s; // Int to single
	logic [127:0] cvt_d2i; // Double to int
	logic [127:0] cvt_i2d; // Int to double

	// ----------------------------------------------------------------
	// Sign mask extraction
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_BYTES; gi++) begin : g_mask
			// Byte gi lands at mask bit gi
			assign sign_mask[gi] = req_i.src[8*gi+7];
			// Byte permute: index in low nibble of the dst byte, sel bit 7 zeroes every byte
			assign bperm[8*gi +: 8] = req_i.sel[7] ? 8'h00 :
				req_i.src[8*req_i.dst[8*gi +: 4] +: 8];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Word and dword shuffles
	// ----------------------------------------------------------------
	generate
		for (gi = 0; gi < 4; gi++) begin : g_shuf
			// Two selector bits per destination word, binary index
			assign shuf_lo[16*gi +: 16] =
				req_i.src[16*req_i.sel[2*gi +: 2] +: 16];
			assign shuf_hi[16*gi +: 16] =
				req_i.src[64 + 16*req_i.sel[2*gi +: 2] +: 16];
			assign dshuf[32*gi +: 32] =
				req_i.src[32*req_i.sel[2*gi +: 2] +: 32];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Conversions, four single lanes and two double lanes
	// ----------------------------------------------------------------
	// Float to int truncates; out of range gives the integer indefinite
	function automatic logic [31:0] f2i(input logic [31:0] f);
		logic [7:0] e;
		logic [55:0] m;
		logic [31:0] v;
		e = f[30:23];
		m = {32'h0, 1'b1, f[22:0]};
		v = 32'h0;
		if (e < 8'd127) begin
			v = 32'h0;
		end else if (e > 8'd157) begin
			v = 32'h80000000;
		end else begin
			if (e >= 8'd150) m = m << (e - 8'd150);
			else m = m >> (8'd150 - e);
			v = f[31] ? 32'(-m[31:0]) : m[31:0];
		end
		return v;
	endfunction : f2i

	// Int to float truncating the mantissa; limits rounding cost
	function automatic logic [31:0] i2f(input logic [31:0] i);
		logic [31:0] a;
		logic [31:0] n;
		logic [4:0] p;
		a = i[31] ? 32'(-i) : i;
		p = 5'd0;
		for (int k = 0; k < 32; k++) begin
			if (a[k]) p = 5'(k);
		end
		n = a << (5'd31 - p);
		return (a == 32'h0) ? 32'h0 : {i[31], 8'(8'd127 + 8'(p)), n[30:8]};
	endfunction : i2f

	// Double exponent onto the single scale; clamps keep tiny values at zero
	// and huge ones on the indefinite path instead of wrapping into range
	function automatic logic [7:0] d2s_exp(input logic [10:0] de);
		logic [7:0] r;
		if (de < 11'd896) r = 8'h00;
		else if (de > 11'd1150) r = 8'hff;
		else r = 8'(de - 11'd896);
		return r;
	endfunction : d2s_exp

	generate
		for (gi = 0; gi < 4; gi++) begin : g_cvt
			assign cvt_s2i[32*gi +: 32] = f2i(req_i.src[32*gi +: 32]);
			assign cvt_i2s[32*gi +: 32] = i2f(req_i.src[32*gi +: 32]);
		end
		for (gi = 0; gi < 2; gi++) begin : g_dcvt
			// Double to int via exponent rebias to single then truncate
			assign cvt_d2i[32*gi +: 32] = f2i({req_i.src[64*gi+63],
				d2s_exp(req_i.src[64*gi+52 +: 11]),
				req_i.src[64*gi+29 +: 23]});
			// Int to double reuses the single result, exponent moved by the bias gap
			assign cvt_i2d[64*gi +: 64] = (req_i.src[32*gi +: 32] == 32'h0) ? 64'h0 :
				{cvt_i2s[32*gi+31],
				11'(11'd896 + 11'(cvt_i2s[32*gi+23 +: 8])),
				cvt_i2s[32*gi +: 23], 29'h0};
		end
		assign cvt_d2i[127:64] = 64'h0;
	endgenerate

	// ----------------------------------------------------------------
	// Packed arithmetic for constant idioms
	// ----------------------------------------------------------------
	// Per-granularity subtract; no carry crosses a field
	function automatic logic [127:0] psub(input logic [127:0] a, input logic [127:0] b,
		input spm_gran_type g);
		logic [127:0] r;
		r = 128'h0;
		for (int k = 0; k < 16; k++) r[8*k +: 8] = a[8*k +: 8] - b[8*k +: 8];
		if (g == SPM_G_WORD) begin
			for (int k = 0; k < 8; k++) r[16*k +: 16] = a[16*k +: 16] - b[16*k +: 16];
		end else if (g == SPM_G_DWORD) begin
			for (int k = 0; k < 4; k++) r[32*k +: 32] = a[32*k +: 32] - b[32*k +: 32];
		end
		return r;
	endfunction : psub

	// Packed equality: all ones in every equal field
	function automatic logic [127:0] pceq(input logic [127:0] a, input logic [127:0] b,
		input spm_gran_type g);
		logic [127:0] r;
		r = 128'h0;
		for (int k = 0; k < 16; k++) r[8*k +: 8] = {8{a[8*k +: 8] == b[8*k +: 8]}};
		if (g == SPM_G_WORD) begin
			for (int k = 0; k < 8; k++) r[16*k +: 16] = {16{a[16*k +: 16] == b[16*k +: 16]}};
		end else if (g == SPM_G_DWORD) begin
			for (int k = 0; k < 4; k++) r[32*k +: 32] = {32{a[32*k +: 32] == b[32*k +: 32]}};
		end
		return r;
	endfunction : pceq

	// Logical shifts, word or dword only; byte requests fall back to word
	function automatic logic [127:0] pshift(input logic [127:0] a, input logic [5:0] n,
		input spm_gran_type g, input logic left);
		logic [127:0] r;
		r = 128'h0;
		if (g == SPM_G_DWORD) begin
			for (int k = 0; k < 4; k++) begin
				if (n > 6'd31) r[32*k +: 32] = 32'h0;
				else if (left) r[32*k +: 32] = a[32*k +: 32] << n;
				else r[32*k +: 32] = a[32*k +: 32] >> n;
			end
		end else begin
			for (int k = 0; k < 8; k++) begin
				if (n > 6'd15) r[16*k +: 16] = 16'h0;
				else if (left) r[16*k +: 16] = a[16*k +: 16] << n;
				else r[16*k +: 16] = a[16*k +: 16] >> n;
			end
		end
		return r;
	endfunction : pshift

	// ----------------------------------------------------------------
	// Result selection
	// ----------------------------------------------------------------
	// No operation loads an immediate into the vector
	always_comb begin
		nxt_res = '0;
		nxt_res.vec_we = req_i.valid;
		unique case (req_i.op)
			SPM_OP_NOP: begin
				nxt_res.vec_we = 1'b0;
			end
			SPM_OP_MASK_NARROW: begin
				// Scalar gets 8 bits, upper 24 zero
				nxt_res.vec_we = 1'b0;
				nxt_res.scalar_we = req_i.valid;
				nxt_res.scalar = {24'h0, sign_mask[7:0]};
			end
			SPM_OP_MASK_WIDE: begin
				nxt_res.vec_we = 1'b0;
				nxt_res.scalar_we = req_i.valid;
				nxt_res.scalar = {16'h0, sign_mask};
			end
			SPM_OP_WORD_SHUF_64: begin
				nxt_res.vec = {64'h0, shuf_lo};
			end
			SPM_OP_LOW_HALF_SHUF: begin
				nxt_res.vec = {req_i.src[127:64], shuf_lo};
			end
			SPM_OP_HIGH_HALF_SHUF: begin
				nxt_res.vec = {shuf_hi, req_i.src[63:0]};
			end
			SPM_OP_DWORD_SHUF: begin
				nxt_res.vec = dshuf;
			end
			SPM_OP_BYTE_PERMUTE: begin
				nxt_res.vec = bperm;
			end
			SPM_OP_QUAD_LOW: begin
				// Only low halves used
				nxt_res.vec = {req_i.src[63:0], req_i.dst[63:0]};
			end
			SPM_OP_QUAD_HIGH: begin
				nxt_res.vec = {req_i.src[127:64], req_i.dst[127:64]};
			end
			SPM_OP_NARROW_TO_WIDE: begin
				nxt_res.vec = {64'h0, req_i.src[63:0]};
			end
			SPM_OP_WIDE_TO_NARROW: begin
				nxt_res.vec = {64'h0, req_i.src[63:0]};
			end
			SPM_OP_CVT_SP_TO_INT: begin
				nxt_res.vec = cvt_s2i;
			end
			SPM_OP_CVT_INT_TO_SP: begin
				nxt_res.vec = cvt_i2s;
			end
			SPM_OP_CVT_DP_TO_INT: begin
				nxt_res.vec = cvt_d2i;
			end
			SPM_OP_CVT_INT_TO_DP: begin
				nxt_res.vec = cvt_i2d;
			end
			SPM_OP_XOR: begin
				nxt_res.vec = req_i.dst ^ req_i.src;
			end
			SPM_OP_CMPEQ: begin
				nxt_res.vec = pceq(req_i.dst, req_i.src, req_i.gran);
			end
			SPM_OP_SUB: begin
				nxt_res.vec = psub(req_i.dst, req_i.src, req_i.gran);
			end
			SPM_OP_SHR: begin
				// Zeros fill from the top
				nxt_res.vec = pshift(req_i.src, req_i.shamt, req_i.gran, 1'b0);
			end
			SPM_OP_SHL: begin
				nxt_res.vec = pshift(req_i.src, req_i.shamt, req_i.gran, 1'b1);
			end
			default: begin
				// Undefined opcode writes nothing
				nxt_res.vec_we = 1'b0;
			end
		endcase
		if (!req_i.valid) begin
			nxt_res.vec_we = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Result register
	// ----------------------------------------------------------------
	// One-cycle latency, cleared by reset
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			res_ff <= '0;
		end else begin
			res_ff <= nxt_res;
		end
	end

	assign res_o = res_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	a_mask_narrow_upper: assert property (req_i.valid && req_i.op == SPM_OP_MASK_NARROW |=>
		res_o.scalar_we && res_o.scalar[31:8] == 24'h0
		&& res_o.scalar[7:0] == {$past(req_i.src[63]), $past(req_i.src[55]),
		$past(req_i.src[47]), $past(req_i.src[39]), $past(req_i.src[31]),
		$past(req_i.src[23]), $past(req_i.src[15]), $past(req_i.src[7])})
		else $error("narrow mask wrong");
	a_mask_wide_upper: assert property (req_i.valid && req_i.op == SPM_OP_MASK_WIDE |=>
		res_o.scalar[31:16] == 16'h0 && res_o.scalar[15] == $past(req_i.src[127]))
		else $error("wide mask wrong");
	a_word_shuf_sel: assert property (req_i.valid && req_i.op == SPM_OP_WORD_SHUF_64
		&& req_i.sel[7:6] == 2'b10 |=> res_o.vec[63:48] == $past(req_i.src[47:32]))
		else $error("word shuffle routing wrong");
	a_half_pass_thru: assert property (req_i.valid && req_i.op == SPM_OP_LOW_HALF_SHUF
		|=> res_o.vec[127:64] == $past(req_i.src[127:64]))
		else $error("low half shuffle high half changed");
	a_dword_shuf_sel: assert property (req_i.valid && req_i.op == SPM_OP_DWORD_SHUF
		|=> res_o.vec[31:0] == $past(req_i.src[32*req_i.sel[1:0] +: 32]))
		else $error("dword shuffle wrong");
	a_quad_low_merge: assert property (req_i.valid && req_i.op == SPM_OP_QUAD_LOW
		|=> res_o.vec == {$past(req_i.src[63:0]), $past(req_i.dst[63:0])})
		else $error("quad interleave low wrong");
	a_n2w_clear_high: assert property (req_i.valid && req_i.op == SPM_OP_NARROW_TO_WIDE
		|=> res_o.vec_we && res_o.vec[127:64] == 64'h0)
		else $error("narrow to wide high half not cleared");
	a_self_xor_zero: assert property (req_i.valid && req_i.op == SPM_OP_XOR
		&& req_i.src == req_i.dst |=> res_o.vec == 128'h0)
		else $error("self xor not zero");
	a_sub_gives_one: assert property (req_i.valid && req_i.op == SPM_OP_SUB
		&& req_i.gran == SPM_G_WORD && req_i.dst == 128'h0 && req_i.src == '1
		|=> res_o.vec == {8{16'h0001}})
		else $error("constant one idiom wrong");
	a_shl_minus_pow: assert property (req_i.valid && req_i.op == SPM_OP_SHL
		&& req_i.gran == SPM_G_DWORD && req_i.src == '1 && req_i.shamt == 6'd4
		|=> res_o.vec == {4{32'hfffffff0}})
		else $error("left shift idiom wrong");
	a_idle_no_write: assert property (!req_i.valid |=> !res_o.vec_we && !res_o.scalar_we)
		else $error("write without request");

	c_mask_wide: cover property (req_i.valid && req_i.op == SPM_OP_MASK_WIDE);
	c_dword_shuf: cover property (req_i.valid && req_i.op == SPM_OP_DWORD_SHUF);
	c_shr_const: cover property (req_i.valid && req_i.op == SPM_OP_SHR && req_i.src == '1);
	c_back_to_back: cover property (req_i.valid ##1 req_i.valid);

endmodule : spm_unit

// file: verification/spm_decoder_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Decoder and register file model feeding one request per edge
// ----------------------------------------------------------------
module spm_decoder_model (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	output spm_pkg::spm_req_type req_o
);
	import spm_pkg::*;

	// Quiet bus until the first issue
	initial begin
		req_o = '0;
	end

	// Present one request at the next edge; calls may follow back to back
	task automatic issue(input spm_op_type op, input spm_gran_type g, input logic [7:0] sel,
		input logic [5:0] sh, input logic [127:0] d, input logic [127:0] s);
		@(posedge sys_clk_i);
		req_o <= '{valid: 1'b1, op: op, gran: g, sel: sel, shamt: sh, dst: d, src: s};
	endtask : issue

	// Drop valid; operands flip so stale values are never mistaken for live ones
	task automatic idle();
		@(posedge sys_clk_i);
		req_o.valid <= 1'b0;
		req_o.dst <= ~req_o.dst;
		req_o.src <= ~req_o.src;
	endtask : idle
endmodule : spm_decoder_model

// file: verification/spm_unit_tb_top.sv
`timescale 1ns/1ps
module spm_unit_tb_top;
	import spm_pkg::*;

	// ----------------------------------------------------------------
	// Clock, reset, wiring
	// ----------------------------------------------------------------
	logic sys_clk_i = 1'b0; // 100 MHz core clock
	logic rst_i = 1'b1; // Held for three rising edges
	spm_req_type req; // Decoder to unit
	spm_res_type res; // Unit write-back
	int fail_count = 0; // Mismatches
	int checks_done = 0; // Comparisons made
	localparam logic [127:0] ONES = '1; // All-ones operand
	localparam logic [127:0] PAT = 128'hffff_eeee_dddd_cccc_0003_0002_0001_0000; // Words 0..3 hold their index

	always #5 sys_clk_i = ~sys_clk_i;

	spm_unit i_spm_unit (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req), .res_o(res));
	spm_decoder_model i_spm_decoder_model (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_o(req));

	// ----------------------------------------------------------------
	// Shared helpers
	// ----------------------------------------------------------------
	// One comparison, reported at once on mismatch
	task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Single request, result sampled mid-cycle after the write-back edge
	task automatic run(input spm_op_type op, input spm_gran_type g, input logic [7:0] sel,
		input logic [5:0] sh, input logic [127:0] d, input logic [127:0] s);
		i_spm_decoder_model.issue(op, g, sel, sh, d, s);
		i_spm_decoder_model.idle();
		@(negedge sys_clk_i);
	endtask : run

	// Counts, verdict and stop
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Sign mask of both widths; upper bytes vary so the narrow form must ignore them
	task automatic t_mask();
		logic [127:0] s = 128'h0180_0180_0180_0180_807f_ff00_0181_c03f;
		logic [31:0] e = '0;
		for (int i = 0; i < 16; i++) e[i] = s[8*i+7];
		run(SPM_OP_MASK_NARROW, SPM_G_BYTE, 8'h00, 6'h00, ONES, s);
		check("mask8", 128'(res.scalar), {96'h0, 24'h0, e[7:0]});
		check("mask8 strobe", 128'({res.scalar_we, res.vec_we}), 128'h2);
		run(SPM_OP_MASK_WIDE, SPM_G_BYTE, 8'h00, 6'h00, ONES, s);
		check("mask16", 128'(res.scalar), {112'h0, e[15:0]});
		check("mask16 strobe", 128'({res.scalar_we, res.vec_we}), 128'h2);
	endtask : t_mask

	// All four word/dword shuffles under several selector bytes
	task automatic t_shuffle();
		spm_op_type ops[4] = '{SPM_OP_WORD_SHUF_64, SPM_OP_LOW_HALF_SHUF,
			SPM_OP_HIGH_HALF_SHUF, SPM_OP_DWORD_SHUF};
		logic [7:0] sels[4] = '{8'h1b, 8'he4, 8'h00, 8'hb1};
		logic [127:0] e;
		logic [1:0] p;
		for (int k = 0; k < 4; k++) begin
			for (int o = 0; o < 4; o++) begin
				e = (o == 0) ? '0 : PAT;
				for (int i = 0; i < 4; i++) begin
					p = sels[k][2*i +: 2];
					case (o)
						0, 1: e[16*i +: 16] = PAT[16*p +: 16];
						2: e[64+16*i +: 16] = PAT[64+16*p +: 16];
						default: e[32*i +: 32] = PAT[32*p +: 32];
					endcase
				end
				run(ops[o], SPM_G_WORD, sels[k], 6'h00, ONES, PAT);
				check("shuffle", res.vec, e);
			end
		end
	endtask : t_shuffle

	// Byte permute with a scattered index table, then the zeroing selector
	task automatic t_byte();
		logic [127:0] d = '0;
		logic [127:0] e;
		for (int i = 0; i < 16; i++) d[8*i +: 8] = 8'((i * 7 + 3) % 16);
		for (int i = 0; i < 16; i++) e[8*i +: 8] = PAT[8*d[8*i +: 4] +: 8];
		run(SPM_OP_BYTE_PERMUTE, SPM_G_BYTE, 8'h00, 6'h00, d, PAT);
		check("permute", res.vec, e);
		run(SPM_OP_BYTE_PERMUTE, SPM_G_BYTE, 8'h80, 6'h00, d, PAT);
		check("permute zero", res.vec, 128'h0);
	endtask : t_byte

	// Interleave both halves; flipping the unused halves must not matter
	task automatic t_quad();
		logic [127:0] d = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
		for (int f = 0; f < 2; f++) begin
			run(SPM_OP_QUAD_LOW, SPM_G_WORD, 8'h00, 6'h00,
				f ? {~d[127:64], d[63:0]} : d, f ? {~PAT[127:64], PAT[63:0]} : PAT);
			check("quad low", res.vec, {PAT[63:0], d[63:0]});
			run(SPM_OP_QUAD_HIGH, SPM_G_WORD, 8'h00, 6'h00,
				f ? {d[127:64], ~d[63:0]} : d, f ? {PAT[127:64], ~PAT[63:0]} : PAT);
			check("quad high", res.vec, {PAT[127:64], d[127:64]});
		end
		run(SPM_OP_NARROW_TO_WIDE, SPM_G_WORD, 8'h00, 6'h00, ONES, PAT);
		check("narrow to wide", res.vec, {64'h0, PAT[63:0]});
		run(SPM_OP_WIDE_TO_NARROW, SPM_G_WORD, 8'h00, 6'h00, ONES, PAT);
		check("wide to narrow", res.vec, {64'h0, PAT[63:0]});
	endtask : t_quad

	// Constant idioms built from register operations, n = 5
	task automatic t_const();
		run(SPM_OP_XOR, SPM_G_WORD, 8'h00, 6'h00, PAT, PAT);
		check("self xor", res.vec, 128'h0);
		run(SPM_OP_CMPEQ, SPM_G_DWORD, 8'h00, 6'h00, PAT, PAT);
		check("self compare", res.vec, ONES);
		run(SPM_OP_SUB, SPM_G_BYTE, 8'h00, 6'h00, '0, ONES);
		check("one byte", res.vec, {16{8'h01}});
		run(SPM_OP_SUB, SPM_G_WORD, 8'h00, 6'h00, '0, ONES);
		check("one word", res.vec, {8{16'h0001}});
		run(SPM_OP_SUB, SPM_G_DWORD, 8'h00, 6'h00, '0, ONES);
		check("one dword", res.vec, {4{32'h1}});
		run(SPM_OP_SHR, SPM_G_WORD, 8'h00, 6'd11, ONES, ONES);
		check("mask word", res.vec, {8{16'h001f}});
		run(SPM_OP_SHR, SPM_G_DWORD, 8'h00, 6'd27, ONES, ONES);
		check("mask dword", res.vec, {4{32'h1f}});
		run(SPM_OP_SHL, SPM_G_WORD, 8'h00, 6'd5, ONES, ONES);
		check("neg word", res.vec, {8{16'hffe0}});
		run(SPM_OP_SHL, SPM_G_DWORD, 8'h00, 6'd5, ONES, ONES);
		check("neg dword", res.vec, {4{32'hffffffe0}});
	endtask : t_const

	// Four-wide single and two-wide double conversions both ways
	task automatic t_cvt();
		logic [127:0] iv = {32'h0, 32'hffffffff, 32'h2, 32'h1};
		logic [127:0] fv = {32'h0, 32'hbf800000, 32'h40000000, 32'h3f800000};
		logic [127:0] dv = {64'h4000000000000000, 64'h3ff0000000000000};
		run(SPM_OP_CVT_INT_TO_SP, SPM_G_DWORD, 8'h00, 6'h00, ONES, iv);
		check("int to single", res.vec, fv);
		run(SPM_OP_CVT_SP_TO_INT, SPM_G_DWORD, 8'h00, 6'h00, ONES, fv);
		check("single to int", res.vec, iv);
		run(SPM_OP_CVT_INT_TO_DP, SPM_G_DWORD, 8'h00, 6'h00, ONES, iv);
		check("int to double", res.vec, dv);
		run(SPM_OP_CVT_DP_TO_INT, SPM_G_DWORD, 8'h00, 6'h00, ONES, dv);
		check("double to int", res.vec, {64'h0, 32'h2, 32'h1});
		run(SPM_OP_CVT_DP_TO_INT, SPM_G_DWORD, 8'h00, 6'h00, ONES,
			{64'hc014000000000000, 64'h4008000000000000});
		check("double to int signed", res.vec, {64'h0, 32'hfffffffb, 32'h3});
	endtask : t_cvt

	// Back-to-back requests, one-cycle strobes, and a refused no-op
	task automatic t_pipe();
		i_spm_decoder_model.issue(SPM_OP_XOR, SPM_G_WORD, 8'h00, 6'h00, PAT, PAT);
		i_spm_decoder_model.issue(SPM_OP_CMPEQ, SPM_G_WORD, 8'h00, 6'h00, PAT, PAT);
		@(negedge sys_clk_i);
		check("first result", {res.vec_we, res.vec}, {1'b1, 128'h0});
		i_spm_decoder_model.idle();
		@(negedge sys_clk_i);
		check("second result", {res.vec_we, res.vec}, {1'b1, ONES});
		@(negedge sys_clk_i);
		check("strobe drop", 128'(res.vec_we), 128'h0);
		run(SPM_OP_NOP, SPM_G_WORD, 8'h00, 6'h00, PAT, PAT);
		check("nop strobes", 128'({res.vec_we, res.scalar_we}), 128'h0);
	endtask : t_pipe

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		@(negedge sys_clk_i);
		check("reset result", res.vec, 128'h0);
		check("reset scalar", 128'({res.vec_we, res.scalar_we, res.scalar}), 128'h0);
		repeat (2) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		t_mask();
		t_shuffle();
		t_byte();
		t_quad();
		t_const();
		t_cvt();
		t_pipe();
		end_sim();
	end

	// A hang counts as a mismatch
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		fail_count++;
		end_sim();
	end
endmodule : spm_unit_tb_top
